// >>> verilog/mac_fc_pkg.sv
package mac_fc_pkg;
  // Watermark register offsets and reset values (bytes free)
  localparam logic [7:0] ADDR_LOW_WM = 8'hb0;
  localparam logic [7:0] ADDR_HIGH_WM = 8'hb2;
  localparam logic [7:0] ADDR_OVR_WM = 8'hb4;
  localparam logic [15:0] LOW_WM_RST = 16'h1400;
  localparam logic [15:0] HIGH_WM_RST = 16'h0c00;
  localparam logic [15:0] OVR_WM_RST = 16'h0100;
  // Timing in bit times, converted to mclk cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS = 100;
  localparam int IPG_BITS = 96;
  localparam int SLOT_BITS = 512;
  localparam int QUANTUM_BITS = 512;
  localparam int FC_FRAME_BITS = 512;
  localparam int BYTE_BITS = 8;
  localparam int IPG_CYC = (IPG_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CYC = (SLOT_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUANTUM_CYC = (QUANTUM_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FC_FRAME_CYC = (FC_FRAME_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_CYC = (BYTE_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Retry policy
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] BACKOFF_LIMIT = 5'h0a;
  // Flow control frame contents
  localparam logic [15:0] PAUSE_MAX = 16'hffff;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XMIT = 3'b001,
    ST_FCTX = 3'b010,
    ST_FLUSH = 3'b011,
    ST_BACKOFF = 3'b100,
    ST_BPHOLD = 3'b101,
    ST_BPGAP = 3'b110
  } tx_state_t;
endpackage : mac_fc_pkg

// >>> verilog/tx_skid_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module tx_skid_buffer #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [1:0] count;
  logic [1:0] next_count;
  logic [WIDTH-1:0] tail;
  logic [WIDTH-1:0] next_head;
  logic [WIDTH-1:0] next_tail;
  logic push;
  logic pop;

  initial begin
    if (WIDTH < 1) $error("tx_skid_buffer: WIDTH must be at least 1");
  end

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_count = count + {1'b0, push} - {1'b0, pop};
    next_head = out_data;
    next_tail = tail;
    if ((count == 2'h0 && push) || (count == 2'h1 && push && pop)) begin
      next_head = in_data;
    end else if (count == 2'h2 && pop) begin
      next_head = tail;
    end
    // Tail only fills once the head is occupied and stays so
    if ((count == 2'h1 && push && !pop) || (count == 2'h2 && push && pop)) begin
      next_tail = in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= 2'h0;
      out_data <= '0;
      tail <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      out_data <= next_head;
      tail <= next_tail;
      in_ready <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
    end
  end
endmodule : tx_skid_buffer
`default_nettype wire

// >>> verilog/mac_tx_flow_control.sv
// Operation
// - 96 bit gap after a good frame
// - After collisions, gap counts from carrier drop
// - Half duplex retries use binary exponential backoff
// - Sixteenth collision drops the frame
// - Collision past 512 bits drops frame
// - Pause frame holds data until timer expires
// - New pause frame reloads running timer
// - Own flow control frames still sent while paused
// - Start pausing at high free-space watermark
// - Stop pausing at low watermark, with hysteresis
// - Drop received frames at overrun watermark
// - Xoff frame carries maximum pause time
// - Xon frame carries zero pause time
// - Half duplex backpressure sends preamble carrier
// - Backpressure carrier drops briefly, then resumes
// - Queued frames interrupt backpressure and go out
// - Backpressure resumes after queued frames leave
// - Collision in backpressure keeps carrier, no backoff
`timescale 1ns/10ps
`default_nettype none
module mac_tx_flow_control
  import mac_fc_pkg::*;
#(
  parameter int BP_HOLD_CYC = 2048,
  parameter int BP_GAP_CYC = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Mode
  input wire logic full_duplex,
  input wire logic bp_enable,
  // Transmit queue
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_done,
  output logic tx_rewind,
  output logic tx_drop,
  // Receive side
  input wire logic [15:0] rx_free,
  input wire logic pause_valid,
  input wire logic [15:0] pause_quanta,
  output logic rx_drop,
  output logic paused,
  // PHY
  input wire logic crs,
  input wire logic col,
  output logic phy_tx_en,
  output logic [7:0] phy_txd,
  output logic fc_frame
);
  localparam int BCNT_W = 16;

  initial begin
    if (BP_HOLD_CYC < 2 || BP_HOLD_CYC > 65535) $error("mac_tx_flow_control: bad BP_HOLD_CYC");
    if (BP_GAP_CYC < 1 || BP_GAP_CYC > 65535) $error("mac_tx_flow_control: bad BP_GAP_CYC");
    if (BYTE_CYC < 2 || BYTE_CYC > 16 || IPG_CYC > 255) $error("mac_tx_flow_control: bad timing");
  end

  function automatic logic [9:0] backoff_mask(input logic [4:0] n);
    logic [4:0] k;
    k = (n > BACKOFF_LIMIT) ? BACKOFF_LIMIT : n;
    backoff_mask = 10'((11'h001 << k) - 11'h001);
  endfunction : backoff_mask

  // Flow state
  logic [15:0] low_thr, high_thr, ovr_thr;
  logic [15:0] next_low_thr, next_high_thr, next_ovr_thr, next_rdata;
  logic xoff, next_xoff, fc_pend, next_fc_pend, fc_taken;
  logic [15:0] fc_val, next_fc_val, pause_cnt, next_pause_cnt, fc_send, next_fc_send;
  logic [9:0] quant_cnt, next_quant_cnt;
  // Transmit state
  tx_state_t state, next_state;
  logic [BCNT_W-1:0] bcnt, next_bcnt;
  logic [3:0] phase, next_phase;
  logic [4:0] attempts, next_attempts;
  logic [9:0] slots, next_slots, bo_cnt, next_bo_cnt;
  logic [15:0] lfsr;
  logic [7:0] gap, next_gap;
  logic last_seen, next_last_seen, flush_retry, next_flush_retry;
  logic next_tx_en, next_fc_frame, next_done, next_rewind, next_drop;
  logic [7:0] next_txd;
  // PHY synchronisers
  logic crs_meta, crs_s, col_meta, col_s;
  // Buffer
  logic buf_valid, buf_ready, buf_last;
  logic [7:0] buf_byte;
  logic gap_ok, bp_wanted, bp_exit;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Stall at the queue instead of losing a byte when the line is busy
  tx_skid_buffer #(.WIDTH(9)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data({tx_last, tx_data}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data({buf_last, buf_byte})
  );

  always_comb begin
    next_low_thr = low_thr;
    next_high_thr = high_thr;
    next_ovr_thr = ovr_thr;
    if (reg_wr && reg_addr == ADDR_LOW_WM) next_low_thr = reg_wdata;
    if (reg_wr && reg_addr == ADDR_HIGH_WM) next_high_thr = reg_wdata;
    if (reg_wr && reg_addr == ADDR_OVR_WM) next_ovr_thr = reg_wdata;
    unique case (reg_addr)
      ADDR_LOW_WM: next_rdata = low_thr;
      ADDR_HIGH_WM: next_rdata = high_thr;
      ADDR_OVR_WM: next_rdata = ovr_thr;
      default: next_rdata = 16'h0000;
    endcase
    // Hysteresis between the two watermarks
    next_xoff = xoff;
    if (rx_free <= high_thr) next_xoff = 1'b1;
    else if (rx_free >= low_thr) next_xoff = 1'b0;
    // A new edge beats the clear from a frame just started
    next_fc_pend = fc_pend && !fc_taken;
    next_fc_val = fc_val;
    if (full_duplex && next_xoff != xoff) begin
      next_fc_pend = 1'b1;
      next_fc_val = next_xoff ? PAUSE_MAX : PAUSE_ZERO;
    end
    next_pause_cnt = pause_cnt;
    next_quant_cnt = quant_cnt;
    if (pause_valid) begin
      next_pause_cnt = pause_quanta;
      next_quant_cnt = 10'h000;
    end else if (pause_cnt != 16'h0000) begin
      if (quant_cnt == 10'(QUANTUM_CYC - 1)) begin
        next_quant_cnt = 10'h000;
        next_pause_cnt = pause_cnt - 16'h0001;
      end else begin
        next_quant_cnt = quant_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_thr <= LOW_WM_RST;
      high_thr <= HIGH_WM_RST;
      ovr_thr <= OVR_WM_RST;
      reg_rdata <= 16'h0000;
      xoff <= 1'b0;
      fc_pend <= 1'b0;
      fc_val <= PAUSE_ZERO;
      pause_cnt <= 16'h0000;
      quant_cnt <= 10'h000;
      paused <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      low_thr <= next_low_thr;
      high_thr <= next_high_thr;
      ovr_thr <= next_ovr_thr;
      reg_rdata <= next_rdata;
      xoff <= next_xoff;
      fc_pend <= next_fc_pend;
      fc_val <= next_fc_val;
      pause_cnt <= next_pause_cnt;
      quant_cnt <= next_quant_cnt;
      paused <= (next_pause_cnt != 16'h0000);
      rx_drop <= (rx_free <= ovr_thr);
    end
  end

  a_pause_reload: assert property (pause_valid |=> pause_cnt == $past(pause_quanta))
    else $error("pause timer not reloaded");
  a_xoff_value: assert property ((full_duplex && !xoff && rx_free <= high_thr) |=> fc_pend && fc_val == 16'hffff)
    else $error("xoff frame lacks maximum pause");
  a_xon_value: assert property ((full_duplex && xoff && rx_free > high_thr && rx_free >= low_thr)
                                |=> fc_pend && fc_val == 16'h0000)
    else $error("xon frame lacks zero pause");
  a_overrun_drop: assert property ((rx_free <= ovr_thr) |=> rx_drop)
    else $error("overrun not dropping");

  always_comb begin
    gap_ok = (gap == 8'(IPG_CYC));
    bp_wanted = xoff && !full_duplex && bp_enable;
    bp_exit = !bp_wanted || (buf_valid && !paused);
    // Gap restarts on own carrier and, in half duplex, on sensed carrier
    if (phy_tx_en || (!full_duplex && crs_s)) next_gap = 8'h00;
    else next_gap = gap_ok ? gap : gap + 8'h01;
    next_state = state;
    next_bcnt = bcnt + 16'h0001;
    next_phase = phase;
    next_attempts = attempts;
    next_slots = slots;
    next_bo_cnt = bo_cnt;
    next_last_seen = last_seen;
    next_flush_retry = flush_retry;
    next_tx_en = phy_tx_en;
    next_txd = phy_txd;
    next_fc_frame = 1'b0;
    next_done = 1'b0;
    next_rewind = 1'b0;
    next_drop = 1'b0;
    fc_taken = 1'b0;
    next_fc_send = fc_send;
    buf_ready = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_tx_en = 1'b0;
        next_bcnt = 16'h0000;
        next_phase = 4'h0;
        next_last_seen = 1'b0;
        if (fc_pend && gap_ok) begin
          next_state = ST_FCTX;
          fc_taken = 1'b1;
          // Frozen so a later watermark edge cannot alter a frame on the line
          next_fc_send = fc_val;
        end else if (buf_valid && !paused && gap_ok) begin
          next_state = ST_XMIT;
        end else if (bp_wanted && !buf_valid) begin
          next_state = ST_BPHOLD;
        end
      end
      ST_XMIT: begin
        if (col_s && !full_duplex) begin
          next_tx_en = 1'b0;
          next_state = ST_FLUSH;
          if (bcnt >= 16'(SLOT_CYC)) begin
            next_flush_retry = 1'b0;
          end else if (attempts == MAX_ATTEMPTS - 5'h01) begin
            next_flush_retry = 1'b0;
          end else begin
            next_flush_retry = 1'b1;
            next_attempts = attempts + 5'h01;
            next_slots = lfsr[9:0] & backoff_mask(attempts + 5'h01);
          end
        end else if (phase == 4'h0) begin
          next_bcnt = bcnt;
          if (last_seen) begin
            next_tx_en = 1'b0;
            next_done = 1'b1;
            next_attempts = 5'h00;
            next_state = ST_IDLE;
          end else if (buf_valid) begin
            buf_ready = 1'b1;
            next_tx_en = 1'b1;
            next_txd = buf_byte;
            next_last_seen = buf_last;
            next_phase = 4'h1;
            next_bcnt = bcnt + 16'h0001;
          end
        end else begin
          next_phase = (phase == 4'(BYTE_CYC - 1)) ? 4'h0 : phase + 4'h1;
        end
      end
      ST_FLUSH: begin
        // Discard the rest of the aborted frame from the buffer
        buf_ready = !last_seen;
        if (last_seen || (buf_valid && buf_last)) begin
          next_rewind = flush_retry;
          next_drop = !flush_retry;
          if (!flush_retry) next_attempts = 5'h00;
          next_bo_cnt = 10'h000;
          next_state = flush_retry ? ST_BACKOFF : ST_IDLE;
        end
      end
      ST_BACKOFF: begin
        if (slots == 10'h000) begin
          next_state = ST_IDLE;
        end else if (bo_cnt == 10'(SLOT_CYC - 1)) begin
          next_bo_cnt = 10'h000;
          next_slots = slots - 10'h001;
        end else begin
          next_bo_cnt = bo_cnt + 10'h001;
        end
      end
      ST_FCTX: begin
        next_tx_en = 1'b1;
        next_fc_frame = 1'b1;
        next_txd = bcnt[3] ? fc_send[7:0] : fc_send[15:8];
        if (bcnt == 16'(FC_FRAME_CYC - 1)) begin
          next_tx_en = 1'b0;
          next_fc_frame = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_BPHOLD: begin
        // Collisions are ignored here so carrier stays up
        next_tx_en = 1'b1;
        next_txd = PREAMBLE_BYTE;
        if (bp_exit) begin
          next_tx_en = 1'b0;
          next_state = ST_IDLE;
        end else if (bcnt == 16'(BP_HOLD_CYC - 1)) begin
          next_tx_en = 1'b0;
          next_bcnt = 16'h0000;
          next_state = ST_BPGAP;
        end
      end
      ST_BPGAP: begin
        next_tx_en = 1'b0;
        if (bp_exit) begin
          next_state = ST_IDLE;
        end else if (bcnt == 16'(BP_GAP_CYC - 1)) begin
          next_tx_en = 1'b1;
          next_txd = PREAMBLE_BYTE;
          next_bcnt = 16'h0000;
          next_state = ST_BPHOLD;
        end
      end
      default: begin
        next_tx_en = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crs_meta <= 1'b0;
      crs_s <= 1'b0;
      col_meta <= 1'b0;
      col_s <= 1'b0;
      state <= ST_IDLE;
      bcnt <= 16'h0000;
      phase <= 4'h0;
      attempts <= 5'h00;
      slots <= 10'h000;
      bo_cnt <= 10'h000;
      lfsr <= 16'hace1;
      gap <= 8'h00;
      last_seen <= 1'b0;
      flush_retry <= 1'b0;
      fc_send <= PAUSE_ZERO;
      phy_tx_en <= 1'b0;
      phy_txd <= 8'h00;
      fc_frame <= 1'b0;
      tx_done <= 1'b0;
      tx_rewind <= 1'b0;
      tx_drop <= 1'b0;
    end else begin
      crs_meta <= crs;
      crs_s <= crs_meta;
      col_meta <= col;
      col_s <= col_meta;
      state <= next_state;
      bcnt <= next_bcnt;
      phase <= next_phase;
      attempts <= next_attempts;
      slots <= next_slots;
      bo_cnt <= next_bo_cnt;
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      gap <= next_gap;
      last_seen <= next_last_seen;
      flush_retry <= next_flush_retry;
      fc_send <= next_fc_send;
      phy_tx_en <= next_tx_en;
      phy_txd <= next_txd;
      fc_frame <= next_fc_frame;
      tx_done <= next_done;
      tx_rewind <= next_rewind;
      tx_drop <= next_drop;
    end
  end

  a_gap_before_tx: assert property ((state == ST_IDLE && next_state inside {ST_XMIT, ST_FCTX}) |-> gap == 8'd96)
    else $error("frame started inside interframe gap");
  a_gap_from_crs: assert property ((!full_duplex && crs_s) |=> gap == 8'h00)
    else $error("gap not restarted by carrier");
  a_attempt_limit: assert property ((state == ST_XMIT && col_s && !full_duplex && attempts == 5'd15)
                                    |=> state == ST_FLUSH && !flush_retry)
    else $error("sixteenth collision retried");
  a_late_drop: assert property ((state == ST_XMIT && col_s && !full_duplex && bcnt >= 16'd512) |=> !flush_retry)
    else $error("late collision retried");
  a_pause_hold: assert property (paused |-> !(state == ST_IDLE && next_state == ST_XMIT))
    else $error("data frame started while paused");
  a_bp_carrier: assert property ((state == ST_BPHOLD && phy_tx_en && col_s && !bp_exit
                                  && bcnt < 16'(BP_HOLD_CYC - 1)) |=> phy_tx_en && state == ST_BPHOLD)
    else $error("backpressure carrier dropped on collision");
  a_backoff_range: assert property ($rose(state == ST_BACKOFF) |-> slots <= backoff_mask(attempts) && $past(flush_retry))
    else $error("backoff entered without retry");
endmodule : mac_tx_flow_control
`default_nettype wire

// >>> test/phy_partner.sv
`timescale 1ns/10ps
`default_nettype none
module phy_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Line from the MAC
  input wire logic phy_tx_en,
  input wire logic [7:0] phy_txd,
  input wire logic fc_frame,
  // Collision request from the bench
  input wire logic col_arm,
  input wire logic [15:0] col_at,
  // Toward the MAC and bench
  output logic crs,
  output logic col,
  output logic [15:0] fc_value
);
  logic [15:0] run;
  logic [2:0] col_left;
  // Carrier echoes our own line a cycle late, as a looped-back PHY would
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run <= 16'h0000;
      col_left <= 3'h0;
      crs <= 1'b0;
      col <= 1'b0;
      fc_value <= 16'h0000;
    end else begin
      run <= phy_tx_en ? run + 16'h0001 : 16'h0000;
      if (col_arm && phy_tx_en && run == col_at)
        col_left <= 3'h4;
      else if (col_left != 3'h0)
        col_left <= col_left - 3'h1;
      col <= (col_left != 3'h0);
      crs <= phy_tx_en || (col_left != 3'h0);
      // Sample mid-byte; high byte leads, so the last pair is the pause value
      if (fc_frame && run[2:0] == 3'h4)
        fc_value <= {fc_value[7:0], phy_txd};
    end
  end
endmodule : phy_partner
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mac_fc_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, full_duplex = 1'b1, bp_enable = 1'b0;
  logic tx_valid = 1'b0, tx_last = 1'b0, pause_valid = 1'b0, col_arm = 1'b0;
  logic [7:0] reg_addr = 8'h00, tx_data = 8'h00, phy_txd;
  logic [15:0] reg_wdata = 16'h0000, rx_free = 16'hffff, pause_quanta = 16'h0000, col_at = 16'h0000;
  logic [15:0] reg_rdata, fc_value;
  logic tx_ready, tx_done, tx_rewind, tx_drop, rx_drop, paused, crs, col, phy_tx_en, fc_frame;
  logic en_q = 1'b0, fc_q = 1'b0;
  int fail_count = 0, compares = 0, cyc = 0, idle = 0, gap = 0, rise_cyc = 0, fc_cnt = 0;

  mac_tx_flow_control #(.BP_HOLD_CYC(16), .BP_GAP_CYC(2)) u_mac_tx_flow_control (.mclk(mclk), .rst(rst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .full_duplex(full_duplex), .bp_enable(bp_enable), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .tx_done(tx_done), .tx_rewind(tx_rewind), .tx_drop(tx_drop),
    .rx_free(rx_free), .pause_valid(pause_valid), .pause_quanta(pause_quanta), .rx_drop(rx_drop),
    .paused(paused), .crs(crs), .col(col), .phy_tx_en(phy_tx_en), .phy_txd(phy_txd), .fc_frame(fc_frame));
  phy_partner u_phy_partner (.mclk(mclk), .rst(rst), .phy_tx_en(phy_tx_en), .phy_txd(phy_txd),
    .fc_frame(fc_frame), .col_arm(col_arm), .col_at(col_at), .crs(crs), .col(col), .fc_value(fc_value));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // Line monitor: idle run before each start, and flow-control frame count
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    idle <= (phy_tx_en || crs) ? 0 : idle + 1;
    en_q <= phy_tx_en;
    fc_q <= fc_frame;
    if (phy_tx_en && !en_q) begin
      gap <= idle;
      rise_cyc <= cyc;
    end
    if (fc_frame && !fc_q)
      fc_cnt <= fc_cnt + 1;
  end

  task automatic finish_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd_reg

  task automatic pulse_pause(input logic [15:0] q);
    @(negedge mclk);
    pause_valid = 1'b1;
    pause_quanta = q;
    @(negedge mclk);
    pause_valid = 1'b0;
  endtask : pulse_pause

  // Result is {drop, rewind, done}; a stalled queue or a silent MAC ends the run
  task automatic send_frame(input int n, output logic [2:0] res);
    int i;
    int k;
    res = 3'b000;
    for (i = 0; i < n; i++) begin
      @(negedge mclk);
      tx_valid = 1'b1;
      tx_data = 8'(8'ha0 + i);
      tx_last = (i == n - 1);
      k = 0;
      // Ready is settled at the falling edge; the next rising edge takes the byte
      while (tx_ready !== 1'b1 && k < 20000) begin
        @(negedge mclk);
        k++;
      end
      if (k >= 20000) begin
        chk(16'h0000, 16'hffff);
        finish_test();
      end
    end
    @(negedge mclk);
    tx_valid = 1'b0;
    tx_last = 1'b0;
    for (k = 0; k < 20000 && res == 3'b000; k++) begin
      @(negedge mclk);
      res = {tx_drop, tx_rewind, tx_done};
    end
    if (res == 3'b000) begin
      chk(16'h0000, 16'hffff);
      finish_test();
    end
  endtask : send_frame

  task automatic window(input int n, output int lows, output int hi, output int ev);
    lows = 0;
    hi = 0;
    ev = 0;
    repeat (n) begin
      @(negedge mclk);
      if (!phy_tx_en)
        lows++;
      if (phy_tx_en && phy_txd === PREAMBLE_BYTE)
        hi++;
      if (tx_rewind || tx_drop)
        ev++;
    end
  endtask : window

  initial begin
    row_t rows[10];
    logic [15:0] v;
    logic [2:0] res;
    int i, c2, lows, hi, ev;
    rows = '{'{1'b0, ADDR_LOW_WM, 16'h0000, LOW_WM_RST}, '{1'b0, ADDR_HIGH_WM, 16'h0000, HIGH_WM_RST},
      '{1'b0, ADDR_OVR_WM, 16'h0000, OVR_WM_RST}, '{1'b1, ADDR_HIGH_WM, 16'h0800, 16'h0800},
      '{1'b1, ADDR_LOW_WM, 16'h1000, 16'h1000}, '{1'b1, ADDR_OVR_WM, 16'h0080, 16'h0080},
      '{1'b1, 8'hb6, 16'h1234, 16'h0000}, '{1'b1, ADDR_LOW_WM, LOW_WM_RST, LOW_WM_RST},
      '{1'b1, ADDR_HIGH_WM, HIGH_WM_RST, HIGH_WM_RST}, '{1'b1, ADDR_OVR_WM, OVR_WM_RST, OVR_WM_RST}};
    tick(3);
    rst = 1'b0;
    tick(2);
    for (i = 0; i < 10; i++) begin
      if (rows[i].wr)
        wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      chk(v, rows[i].e);
    end
    $display("test registers done");
    send_frame(4, res);
    send_frame(4, res);
    chk(16'(res), 16'h0001);
    chk(16'(gap >= IPG_CYC), 16'h0001);
    $display("test gap done");
    pulse_pause(16'h0001);
    tick(100);
    pulse_pause(16'h0002);
    c2 = cyc;
    rx_free = HIGH_WM_RST;
    tick(700);
    chk(16'(paused), 16'h0001);
    chk(fc_value, PAUSE_MAX);
    send_frame(4, res);
    chk(16'((rise_cyc - c2) >= 2 * QUANTUM_CYC - 4), 16'h0001);
    rx_free = 16'h1000;
    tick(700);
    chk(16'(fc_cnt), 16'h0001);
    rx_free = LOW_WM_RST;
    tick(700);
    chk(16'(fc_cnt), 16'h0002);
    chk(fc_value, PAUSE_ZERO);
    rx_free = OVR_WM_RST;
    tick(3);
    chk(16'(rx_drop), 16'h0001);
    rx_free = OVR_WM_RST + 16'h0001;
    tick(3);
    chk(16'(rx_drop), 16'h0000);
    rx_free = 16'hffff;
    tick(500);
    chk(fc_value, PAUSE_MAX);
    tick(700);
    $display("test flow control done");
    full_duplex = 1'b0;
    col_arm = 1'b1;
    col_at = 16'd20;
    send_frame(10, res);
    chk(16'(res), 16'h0002);
    col_arm = 1'b0;
    send_frame(10, res);
    chk(16'(res), 16'h0001);
    chk(16'(gap >= IPG_CYC), 16'h0001);
    col_arm = 1'b1;
    col_at = 16'd560;
    // Past the slot time, so no retry may follow
    send_frame(72, res);
    chk(16'(res), 16'h0004);
    $display("test collisions done");
    col_arm = 1'b0;
    bp_enable = 1'b1;
    rx_free = HIGH_WM_RST;
    tick(40);
    window(40, lows, hi, ev);
    chk(16'(hi >= 32), 16'h0001);
    chk(16'(lows >= 2 && lows <= 8), 16'h0001);
    send_frame(4, res);
    chk(16'(res), 16'h0001);
    tick(150);
    window(40, lows, hi, ev);
    chk(16'(hi >= 32), 16'h0001);
    col_arm = 1'b1;
    col_at = 16'd3;
    window(40, lows, hi, ev);
    chk(16'(lows <= 8 && hi >= 28), 16'h0001);
    chk(16'(ev), 16'h0000);
    col_arm = 1'b0;
    rx_free = 16'hffff;
    tick(200);
    window(20, lows, hi, ev);
    chk(16'(lows), 16'd20);
    $display("test backpressure done");
    rx_free = OVR_WM_RST;
    wr_reg(ADDR_HIGH_WM, 16'h0400);
    rst = 1'b1;
    tick(3);
    chk(16'(rx_drop), 16'h0000);
    rst = 1'b0;
    tick(2);
    chk(16'(rx_drop), 16'h0001);
    rd_reg(ADDR_HIGH_WM, v);
    chk(v, HIGH_WM_RST);
    rx_free = 16'hffff;
    $display("test reset done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
